// *** dsr_far_side.sv ***
// Model of the start switches and the external converter facing the drive
`timescale 1ns/1ps
module dsr_far_side (
  input wire logic clk,
  output logic forward_start_input,
  output logic reverse_start_input,
  output logic conv_ready_input,
  output logic run_enable_input,
  output logic output_stop_input
);
  // ==========================================
  // Idle state: converter healthy, output allowed, switches open
  initial
  begin
    forward_start_input = 1'b0;
    reverse_start_input = 1'b0;
    conv_ready_input = 1'b0;
    run_enable_input = 1'b1;
    output_stop_input = 1'b0;
  end

  // ==========================================
  // Switch and converter actions, each launched just after a clock edge
  task automatic set_start(input logic fwd, input logic rev);
    @(posedge clk);
    forward_start_input <= fwd;
    reverse_start_input <= rev;
  endtask : set_start

  // Ready high flags a supply loss seen by the converter
  task automatic power(input logic fail);
    @(posedge clk);
    conv_ready_input <= fail;
  endtask : power

  task automatic enable(input logic en);
    @(posedge clk);
    run_enable_input <= en;
  endtask : enable

  // Output stop may stand in for run enable to block the drive
  task automatic ostop(input logic v);
    @(posedge clk);
    output_stop_input <= v;
  endtask : ostop
endmodule : dsr_far_side

// *** dsr_pkg.sv ***
// Constants shared by the stop and regeneration control block
package dsr_pkg;
  // ==========================================
  // Register indices
  localparam logic [3:0] A_STOP_SEL = 4'h0;
  localparam logic [3:0] A_REGEN_FUNC = 4'h1;
  localparam logic [3:0] A_DUTY_SET = 4'h2;
  localparam logic [3:0] A_RESTART = 4'h3;
  localparam logic [3:0] A_START_FREQ = 4'h4;
  localparam logic [3:0] A_TERM_SEL = 4'h5;
  localparam logic [3:0] A_CTRL = 4'h6;
  localparam logic [3:0] A_FREQ_CMD = 4'h7;
  localparam logic [3:0] A_STATUS = 4'h8;
  localparam logic [3:0] A_IRQ_STAT = 4'h9;
  localparam logic [3:0] A_IRQ_MASK = 4'ha;
  // ==========================================
  // Reset values and setting codes
  localparam logic [15:0] STOP_SEL_RST = 16'h270f;
  localparam logic [15:0] RESTART_OFF = 16'h270f;
  localparam logic [15:0] SEL_PAIRED_DECEL = 16'h22b8;
  localparam logic [15:0] SEL_DELAY_MAX = 16'h0064;
  localparam logic [15:0] SEL_OFS_MIN = 16'h03e8;
  localparam logic [15:0] SEL_OFS_MAX = 16'h044c;
  localparam logic [7:0] TERM_ALARM_POS = 8'h07;
  localparam logic [7:0] TERM_ALARM_NEG = 8'h6b;
  localparam logic [15:0] WARN_PCT = 16'h0055;
  localparam logic [15:0] FULL_PCT = 16'h0064;
  // ==========================================
  // Field positions
  localparam int P_FWD = 0;
  localparam int P_REV = 1;
  localparam int P_RDY = 2;
  localparam int P_EN = 3;
  localparam int P_OSTOP = 4;
  localparam int PIN_W = 5;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_PFAIL = 2;
  localparam int IRQ_SHUT = 3;
  localparam int IRQ_W = 4;
  localparam int CTRL_CLR = 4;
  // ==========================================
  // Timing
  localparam int TICK_S = 1;
  localparam int CLK_HZ = 125_000_000;
  localparam int SEC_CYCLES = TICK_S * CLK_HZ;
  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_PFAIL, ST_SEARCH} dsr_state_t;
endpackage : dsr_pkg

// *** dsr_stop_ctrl.sv ***
// Stop method, power failure restart and regeneration duty control
`timescale 1ns/1ps
module dsr_stop_ctrl #(
  parameter int unsigned SEC_CYCLES = dsr_pkg::SEC_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic forward_start_input,
  input wire logic reverse_start_input,
  input wire logic conv_ready_input,
  input wire logic run_enable_input,
  input wire logic output_stop_input,
  input wire logic [7:0] regen_duty_meas,
  input wire logic [15:0] detected_speed,
  output logic drive_enable,
  output logic run_status,
  output logic reverse_dir,
  output logic [15:0] out_freq,
  output logic speed_search,
  output logic regen_duty_alarm,
  output logic regen_duty_alarm_term,
  output logic regen_warning_indication,
  output logic regen_overvoltage_fault,
  output logic irq
);
  // ==========================================
  // Registers
  logic [15:0] stop_method_select_ff;
  logic [7:0] regen_function_selector_ff;
  logic [7:0] regen_brake_duty_setting_ff;
  logic [15:0] restart_coast_time_ff;
  logic [15:0] starting_frequency_setting_ff;
  logic [7:0] output_terminal_selector_ff;
  logic [3:0] ctrl_ff;
  logic [15:0] freq_cmd_ff;
  logic [dsr_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [dsr_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [15:0] rdata_ff;
  logic irq_ff;
  logic wr_irq;
  logic fault_clr;

  assign wr_irq = reg_wr && reg_addr == dsr_pkg::A_IRQ_STAT;
  assign fault_clr = reg_wr && reg_addr == dsr_pkg::A_CTRL && reg_wdata[dsr_pkg::CTRL_CLR];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stop_method_select_ff <= dsr_pkg::STOP_SEL_RST;
      regen_function_selector_ff <= 8'h00;
      regen_brake_duty_setting_ff <= 8'h00;
      restart_coast_time_ff <= dsr_pkg::RESTART_OFF;
      starting_frequency_setting_ff <= 16'h0000;
      output_terminal_selector_ff <= 8'h00;
      ctrl_ff <= 4'h0;
      freq_cmd_ff <= 16'h0000;
      irq_mask_ff <= '0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        dsr_pkg::A_STOP_SEL: stop_method_select_ff <= reg_wdata;
        dsr_pkg::A_REGEN_FUNC: regen_function_selector_ff <= reg_wdata[7:0];
        dsr_pkg::A_DUTY_SET: regen_brake_duty_setting_ff <= reg_wdata[7:0];
        dsr_pkg::A_RESTART: restart_coast_time_ff <= reg_wdata;
        dsr_pkg::A_START_FREQ: starting_frequency_setting_ff <= reg_wdata;
        dsr_pkg::A_TERM_SEL: output_terminal_selector_ff <= reg_wdata[7:0];
        dsr_pkg::A_CTRL: ctrl_ff <= reg_wdata[3:0];
        dsr_pkg::A_FREQ_CMD: freq_cmd_ff <= reg_wdata;
        dsr_pkg::A_IRQ_MASK: irq_mask_ff <= reg_wdata[dsr_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // Pin synchronisers
  logic [dsr_pkg::PIN_W-1:0] pin_s1_ff;
  logic [dsr_pkg::PIN_W-1:0] pin_s2_ff;
  logic fwd, rev, rdy, en_ok;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end
    else
    begin
      pin_s1_ff <= {output_stop_input, run_enable_input, conv_ready_input,
                    reverse_start_input, forward_start_input};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign fwd = pin_s2_ff[dsr_pkg::P_FWD];
  assign rev = pin_s2_ff[dsr_pkg::P_REV];
  assign rdy = pin_s2_ff[dsr_pkg::P_RDY];
  // Either blocking input holds the output off
  assign en_ok = pin_s2_ff[dsr_pkg::P_EN] && !pin_s2_ff[dsr_pkg::P_OSTOP];

  // ==========================================
  // Stop method decode
  logic ofs_range, paired, override, delay_mode, start_cmd, dir_cmd, restart_en;
  logic [15:0] delay_s;

  assign ofs_range = stop_method_select_ff >= dsr_pkg::SEL_OFS_MIN
                     && stop_method_select_ff <= dsr_pkg::SEL_OFS_MAX;
  assign paired = ofs_range || stop_method_select_ff == dsr_pkg::SEL_PAIRED_DECEL;
  assign override = |ctrl_ff;
  assign delay_mode = !override
                      && (stop_method_select_ff <= dsr_pkg::SEL_DELAY_MAX || ofs_range);
  assign delay_s = ofs_range ? stop_method_select_ff - dsr_pkg::SEL_OFS_MIN
                             : stop_method_select_ff;
  assign start_cmd = paired ? fwd : (fwd || rev);
  assign dir_cmd = paired ? rev : (rev && !fwd);
  // Restart only if software enabled it (selector expected at 2 then)
  assign restart_en = restart_coast_time_ff != dsr_pkg::RESTART_OFF;

  // ==========================================
  // Coast delay timer
  logic [26:0] pre_ff;
  logic [15:0] sec_ff;
  logic timing_ff;
  logic start_q_ff;
  logic expire;
  dsr_pkg::dsr_state_t state_ff, nxt_state;

  assign expire = timing_ff && sec_ff >= delay_s;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pre_ff <= 27'h0;
      sec_ff <= 16'h0;
      timing_ff <= 1'b0;
      start_q_ff <= 1'b0;
    end
    else
    begin
      start_q_ff <= start_cmd;
      if (start_cmd || state_ff != dsr_pkg::ST_RUN)
        timing_ff <= 1'b0;
      else if (start_q_ff)
      begin
        pre_ff <= 27'h0;
        sec_ff <= 16'h0;
        timing_ff <= 1'b1;
      end
      else if (timing_ff && !expire)
      begin
        if (pre_ff == 27'(SEC_CYCLES - 1))
        begin
          pre_ff <= 27'h0;
          sec_ff <= sec_ff + 16'h1;
        end
        else
          pre_ff <= pre_ff + 27'h1;
      end
    end
  end

  // ==========================================
  // Run state machine
  logic fault_ff;
  logic trip;
  logic [15:0] freq_ff;

  // Only the fault and the enable inputs trip; the duty alarm never does
  assign trip = fault_ff || !en_ok;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      dsr_pkg::ST_IDLE:
        if (start_cmd && !trip && !rdy)
          nxt_state = dsr_pkg::ST_RUN;
      dsr_pkg::ST_RUN:
        if (trip)
          nxt_state = dsr_pkg::ST_IDLE;
        else if (rdy)
          nxt_state = dsr_pkg::ST_PFAIL;
        else if (!start_cmd && !delay_mode)
          nxt_state = dsr_pkg::ST_DECEL;
        else if (!start_cmd && expire)
          nxt_state = dsr_pkg::ST_IDLE;
      dsr_pkg::ST_DECEL:
        if (trip)
          nxt_state = dsr_pkg::ST_IDLE;
        else if (rdy)
          nxt_state = dsr_pkg::ST_PFAIL;
        else if (start_cmd)
          nxt_state = dsr_pkg::ST_RUN;
        else if (freq_ff == 16'h0)
          nxt_state = dsr_pkg::ST_IDLE;
      dsr_pkg::ST_PFAIL:
        if (!rdy)
          nxt_state = restart_en && !trip ? dsr_pkg::ST_SEARCH
                                          : dsr_pkg::ST_IDLE;
      dsr_pkg::ST_SEARCH:
        nxt_state = trip ? dsr_pkg::ST_IDLE : dsr_pkg::ST_RUN;
      default:
        nxt_state = dsr_pkg::ST_IDLE;
    endcase
  end

  logic drive_en_ff, dir_ff, search_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_ff <= dsr_pkg::ST_IDLE;
      drive_en_ff <= 1'b0;
      dir_ff <= 1'b0;
      search_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      // Running status is the output gate itself, so both drop together
      drive_en_ff <= nxt_state == dsr_pkg::ST_RUN || nxt_state == dsr_pkg::ST_DECEL
                     || nxt_state == dsr_pkg::ST_SEARCH;
      search_ff <= nxt_state == dsr_pkg::ST_SEARCH && state_ff != dsr_pkg::ST_SEARCH;
      if (nxt_state == dsr_pkg::ST_RUN && start_cmd)
        dir_ff <= dir_cmd;
    end
  end

  // ==========================================
  // Output frequency ramp, one step per clock
  logic [15:0] tgt;

  assign tgt = state_ff == dsr_pkg::ST_DECEL ? 16'h0 : freq_cmd_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      freq_ff <= 16'h0;
    else if (nxt_state == dsr_pkg::ST_SEARCH)
      freq_ff <= detected_speed;
    else if (state_ff == dsr_pkg::ST_IDLE && nxt_state == dsr_pkg::ST_RUN)
      freq_ff <= starting_frequency_setting_ff;
    else if (nxt_state == dsr_pkg::ST_IDLE || nxt_state == dsr_pkg::ST_PFAIL)
      freq_ff <= 16'h0;
    else if (freq_ff < tgt)
      freq_ff <= freq_ff + 16'h1;
    else if (freq_ff > tgt)
      freq_ff <= freq_ff - 16'h1;
  end

  // ==========================================
  // Regenerative duty supervision
  logic warn, full;
  logic alarm_ff, term_ff, ind_ff;

  // Measured duty is in the same percent units as the duty setting
  assign warn = regen_brake_duty_setting_ff != 8'h0
                && 16'(regen_duty_meas) * dsr_pkg::FULL_PCT
                   >= 16'(regen_brake_duty_setting_ff) * dsr_pkg::WARN_PCT;
  assign full = regen_brake_duty_setting_ff != 8'h0
                && regen_duty_meas >= regen_brake_duty_setting_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      alarm_ff <= 1'b0;
      ind_ff <= 1'b0;
      term_ff <= 1'b0;
      fault_ff <= 1'b0;
    end
    else
    begin
      alarm_ff <= warn;
      ind_ff <= warn && regen_function_selector_ff != 8'h0;
      if (output_terminal_selector_ff == dsr_pkg::TERM_ALARM_POS)
        term_ff <= alarm_ff;
      else if (output_terminal_selector_ff == dsr_pkg::TERM_ALARM_NEG)
        term_ff <= !alarm_ff;
      else
        term_ff <= 1'b0;
      // A new overload wins over a clear in the same cycle
      if (full)
        fault_ff <= 1'b1;
      else if (fault_clr)
        fault_ff <= 1'b0;
    end
  end

  // ==========================================
  // Interrupts and read port
  logic [dsr_pkg::IRQ_W-1:0] ev;
  logic [15:0] status;

  assign ev = {drive_en_ff && !(drive_en_ff && nxt_state != dsr_pkg::ST_IDLE
                                && nxt_state != dsr_pkg::ST_PFAIL),
               state_ff != dsr_pkg::ST_PFAIL && nxt_state == dsr_pkg::ST_PFAIL,
               full && !fault_ff,
               warn && !alarm_ff};
  assign status = {8'h0, fault_ff, alarm_ff, rdy, en_ok, dir_ff, state_ff};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
      rdata_ff <= 16'h0;
    end
    else
    begin
      irq_stat_ff <= (irq_stat_ff & ~(wr_irq ? reg_wdata[dsr_pkg::IRQ_W-1:0] : '0)) | ev;
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
      rdata_ff <= 16'h0;
      if (reg_rd)
      begin
        unique case (reg_addr)
          dsr_pkg::A_STOP_SEL: rdata_ff <= stop_method_select_ff;
          dsr_pkg::A_REGEN_FUNC: rdata_ff <= {8'h0, regen_function_selector_ff};
          dsr_pkg::A_DUTY_SET: rdata_ff <= {8'h0, regen_brake_duty_setting_ff};
          dsr_pkg::A_RESTART: rdata_ff <= restart_coast_time_ff;
          dsr_pkg::A_START_FREQ: rdata_ff <= starting_frequency_setting_ff;
          dsr_pkg::A_TERM_SEL: rdata_ff <= {8'h0, output_terminal_selector_ff};
          dsr_pkg::A_CTRL: rdata_ff <= {12'h0, ctrl_ff};
          dsr_pkg::A_FREQ_CMD: rdata_ff <= freq_cmd_ff;
          dsr_pkg::A_STATUS: rdata_ff <= status;
          dsr_pkg::A_IRQ_STAT: rdata_ff <= {12'h0, irq_stat_ff};
          dsr_pkg::A_IRQ_MASK: rdata_ff <= {12'h0, irq_mask_ff};
          default: rdata_ff <= 16'h0;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign drive_enable = drive_en_ff;
  assign run_status = drive_en_ff;
  assign reverse_dir = dir_ff;
  assign out_freq = freq_ff;
  assign speed_search = search_ff;
  assign regen_duty_alarm = alarm_ff;
  assign regen_duty_alarm_term = term_ff;
  assign regen_warning_indication = ind_ff;
  assign regen_overvoltage_fault = fault_ff;
  assign irq = irq_ff;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  pfail_coast_a: assert property (
    (state_ff == dsr_pkg::ST_RUN && rdy && !trip) |=> !drive_en_ff && !run_status)
    else $error("output not cut on power failure");
  restart_a: assert property (
    (state_ff == dsr_pkg::ST_PFAIL && !rdy && restart_en && !trip)
      |=> search_ff && drive_en_ff ##1 state_ff == dsr_pkg::ST_RUN)
    else $error("no restart after power return");
  warn_alarm_a: assert property (
    warn |=> alarm_ff) else $error("duty alarm missing");
  duty_fault_a: assert property (
    full |=> fault_ff) else $error("duty fault missing");
  ind_off_a: assert property (
    regen_function_selector_ff == 8'h0 |=> !ind_ff) else $error("indication not suppressed");
  term_route_a: assert property (
    output_terminal_selector_ff == dsr_pkg::TERM_ALARM_NEG |=> term_ff == !$past(alarm_ff))
    else $error("negative alarm routing wrong");
  decel_stop_a: assert property (
    (state_ff == dsr_pkg::ST_RUN && !start_cmd && !delay_mode && !trip && !rdy)
      |=> state_ff == dsr_pkg::ST_DECEL && drive_en_ff)
    else $error("no ramp down on release");
  delay_cut_a: assert property (
    (state_ff == dsr_pkg::ST_RUN && !start_cmd && expire && delay_mode && !rdy)
      |=> !drive_en_ff) else $error("delayed shutoff missing");
  start_freq_a: assert property (
    (state_ff == dsr_pkg::ST_IDLE && nxt_state == dsr_pkg::ST_RUN)
      |=> out_freq == $past(starting_frequency_setting_ff))
    else $error("restart not at starting frequency");
  enable_off_a: assert property (
    !en_ok |=> !drive_en_ff) else $error("output on without enable");
endmodule : dsr_stop_ctrl

// *** tb_top.sv ***
// Self-checking testbench for the stop and regeneration control block
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic sys_rst;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] regen_duty_meas;
  logic [15:0] detected_speed;
  logic saw_search = 1'b0;
  logic [15:0] d;
  wire logic [15:0] reg_rdata;
  wire logic [15:0] out_freq;
  wire logic fwd, rev, rdy, en, ostop;
  wire logic drive_enable, run_status, reverse_dir, speed_search;
  wire logic alarm, alarm_term, warn, fault, irq;
  int miscompares = 0;
  int total_checks = 0;
  int n;

  always #4 clk = ~clk;

  always @(posedge clk)
    if (speed_search === 1'b1)
      saw_search <= 1'b1;

  // ==========================================
  // Design and far side
  dsr_stop_ctrl #(.SEC_CYCLES(10)) dsr_stop_ctrl_inst (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .forward_start_input(fwd), .reverse_start_input(rev), .conv_ready_input(rdy),
    .run_enable_input(en), .output_stop_input(ostop), .regen_duty_meas(regen_duty_meas),
    .detected_speed(detected_speed), .drive_enable(drive_enable), .run_status(run_status),
    .reverse_dir(reverse_dir), .out_freq(out_freq), .speed_search(speed_search),
    .regen_duty_alarm(alarm), .regen_duty_alarm_term(alarm_term),
    .regen_warning_indication(warn), .regen_overvoltage_fault(fault), .irq(irq)
  );

  dsr_far_side dsr_far_side_inst (
    .clk(clk), .forward_start_input(fwd), .reverse_start_input(rev),
    .conv_ready_input(rdy), .run_enable_input(en), .output_stop_input(ostop)
  );

  // ==========================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Checks made %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : idle

  // Bounded wait for the output stage; n keeps the cycles it took
  task automatic wait_drv(input logic v, input int lim);
    // Step off the edge so a change launched there is already visible
    #1;
    n = 0;
    while (drive_enable !== v && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(drive_enable), 16'(v), "drive enable");
  endtask : wait_drv

  task automatic run();
    dsr_far_side_inst.set_start(1'b1, 1'b0);
    wait_drv(1'b1, 10);
    idle(40);
  endtask : run

  // ==========================================
  // Watchdog: the whole sequence needs well under 10000 cycles
  initial
  begin
    #400000;
    miscompares++;
    summarize();
  end

  // ==========================================
  // Test sequence
  initial
  begin
    sys_rst <= 1'b1;
    reg_addr <= 4'h0;
    reg_wdata <= 16'h0000;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    regen_duty_meas <= 8'h00;
    detected_speed <= 16'h0020;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(dsr_pkg::A_STOP_SEL);
    check(d, dsr_pkg::STOP_SEL_RST, "stop select reset");
    rd(dsr_pkg::A_RESTART);
    check(d, dsr_pkg::RESTART_OFF, "restart reset");
    rd(4'hf);
    check(d, 16'h0000, "unmapped read");
    wr(dsr_pkg::A_REGEN_FUNC, 16'h0002);
    wr(dsr_pkg::A_RESTART, 16'h0000);
    wr(dsr_pkg::A_START_FREQ, 16'h0005);
    wr(dsr_pkg::A_FREQ_CMD, 16'h0020);
    wr(dsr_pkg::A_DUTY_SET, 16'h0014);
    wr(dsr_pkg::A_TERM_SEL, 16'h0007);
    wr(dsr_pkg::A_IRQ_MASK, 16'h0004);
    // Ramp stop with duty alarm while running
    run();
    check(16'(run_status), 16'h0001, "running");
    check(out_freq, 16'h0020, "command reached");
    regen_duty_meas <= 8'h11;
    idle(6);
    check(16'(alarm), 16'h0001, "alarm at 85");
    check(16'(warn), 16'h0001, "warning shown");
    check(16'(alarm_term), 16'h0001, "terminal high");
    check(16'(drive_enable), 16'h0001, "alarm no trip");
    wr(dsr_pkg::A_TERM_SEL, 16'h006b);
    idle(3);
    check(16'(alarm_term), 16'h0000, "terminal low");
    wr(dsr_pkg::A_REGEN_FUNC, 16'h0000);
    idle(3);
    check(16'(warn), 16'h0000, "warning hidden");
    wr(dsr_pkg::A_REGEN_FUNC, 16'h0002);
    rd(dsr_pkg::A_IRQ_STAT);
    check(16'(d[0]), 16'h0001, "alarm event");
    check(16'(irq), 16'h0000, "masked irq");
    dsr_far_side_inst.set_start(1'b0, 1'b0);
    wait_drv(1'b0, 60);
    check(out_freq, 16'h0000, "ramped to zero");
    check(16'(n >= 20), 16'h0001, "not cut at once");
    // Duty limit trips the output; clear it afterwards
    run();
    regen_duty_meas <= 8'h14;
    wait_drv(1'b0, 10);
    check(16'(fault), 16'h0001, "fault raised");
    regen_duty_meas <= 8'h00;
    dsr_far_side_inst.set_start(1'b0, 1'b0);
    wr(dsr_pkg::A_CTRL, 16'h0010);
    idle(3);
    check(16'(fault), 16'h0000, "fault cleared");
    // Delayed shutoff of 3 s; re-press restarts the timer
    wr(dsr_pkg::A_STOP_SEL, 16'h0003);
    run();
    dsr_far_side_inst.set_start(1'b0, 1'b0);
    idle(15);
    dsr_far_side_inst.set_start(1'b1, 1'b0);
    idle(40);
    check(16'(drive_enable), 16'h0001, "timer cancelled");
    dsr_far_side_inst.set_start(1'b0, 1'b0);
    wr(dsr_pkg::A_FREQ_CMD, 16'h0010);
    idle(20);
    check(out_freq, 16'h0010, "tracks command");
    check(16'(drive_enable), 16'h0001, "still driving");
    wait_drv(1'b0, 20);
    check(16'(n >= 6 && n <= 14), 16'h0001, "delay length");
    check(16'(run_status), 16'h0000, "run dropped");
    dsr_far_side_inst.set_start(1'b1, 1'b0);
    wait_drv(1'b1, 10);
    check(out_freq, 16'h0005, "restart at start freq");
    dsr_far_side_inst.set_start(1'b0, 1'b0);
    wait_drv(1'b0, 50);
    // Paired terminals with offset delay of 2 s
    wr(dsr_pkg::A_STOP_SEL, 16'h03ea);
    dsr_far_side_inst.set_start(1'b0, 1'b1);
    idle(10);
    check(16'(drive_enable), 16'h0000, "direction only");
    dsr_far_side_inst.set_start(1'b1, 1'b1);
    wait_drv(1'b1, 10);
    check(16'(reverse_dir), 16'h0001, "reverse selected");
    idle(20);
    dsr_far_side_inst.set_start(1'b0, 1'b1);
    wait_drv(1'b0, 40);
    check(16'(n >= 18 && n <= 26), 16'h0001, "offset delay");
    wr(dsr_pkg::A_STOP_SEL, 16'h270f);
    dsr_far_side_inst.set_start(1'b0, 1'b1);
    wait_drv(1'b1, 10);
    check(16'(reverse_dir), 16'h0001, "reverse start");
    dsr_far_side_inst.set_start(1'b0, 1'b0);
    wait_drv(1'b0, 60);
    // Each special stop overrides a 100 s delay
    wr(dsr_pkg::A_STOP_SEL, 16'h0064);
    for (int i = 0; i < 4; i++)
    begin
      run();
      wr(dsr_pkg::A_CTRL, 16'h0001 << i);
      dsr_far_side_inst.set_start(1'b0, 1'b0);
      wait_drv(1'b0, 80);
      wr(dsr_pkg::A_CTRL, 16'h0000);
    end
    // Power failure, recovery, run enable and output stop
    run();
    dsr_far_side_inst.power(1'b1);
    wait_drv(1'b0, 6);
    rd(dsr_pkg::A_IRQ_STAT);
    check(16'(d[2]), 16'h0001, "power fail event");
    check(16'(irq), 16'h0001, "irq raised");
    wr(dsr_pkg::A_IRQ_STAT, 16'h000f);
    idle(3);
    check(16'(irq), 16'h0000, "irq cleared");
    // Found speed differs from the command so a plain ramp cannot pass
    detected_speed <= 16'h0018;
    dsr_far_side_inst.power(1'b0);
    wait_drv(1'b1, 8);
    check(out_freq, 16'h0018, "speed taken over");
    idle(1);
    check(16'(saw_search), 16'h0001, "speed search");
    dsr_far_side_inst.enable(1'b0);
    wait_drv(1'b0, 6);
    dsr_far_side_inst.set_start(1'b0, 1'b0);
    dsr_far_side_inst.enable(1'b1);
    dsr_far_side_inst.ostop(1'b1);
    dsr_far_side_inst.set_start(1'b1, 1'b0);
    idle(10);
    check(16'(drive_enable), 16'h0000, "output stop blocks");
    dsr_far_side_inst.ostop(1'b0);
    wait_drv(1'b1, 10);
    summarize();
  end
endmodule : tb_top
